//--- test/host_seq.sv
// host model that steps a command table into the module's point window
`timescale 1ns/1ps
module host_seq #(
  parameter int N = 5,
  parameter logic [N*16-1:0] TBL = {16'h0000, 16'h0011, 16'h5A3C, 16'h0021, 16'h0006}
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic one,
  input wire logic [31:0] one_word,
  output logic scan_strobe,
  output logic [31:0] cmd_points,
  output logic busy
);
  // load codes 0x21 to 0x3F of this table carry three data bytes
  function automatic logic needs_data(input logic [7:0] c);
    needs_data = c >= 8'h21 && c <= 8'h3F;
  endfunction
  int ptr;
  int step;
  logic [7:0] code_buf;
  logic [15:0] d12_buf;
  logic [7:0] d3_buf;
  always_comb begin
    step = 1;
    code_buf = TBL[ptr*16 +: 8];
    d12_buf = 16'h0000;
    d3_buf = 8'h00;
    if (needs_data(code_buf) && ptr + 2 < N) begin
      step = 3;
      d12_buf = TBL[(ptr+1)*16 +: 16];
      d3_buf = TBL[(ptr+2)*16 +: 8];
    end
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr <= 0;
      busy <= 0;
      scan_strobe <= 0;
      cmd_points <= 32'h0;
    end else begin
      scan_strobe <= 0;
      if (start) begin
        ptr <= 0;
        busy <= 1;
      end else if (one) begin
        cmd_points <= one_word;
        scan_strobe <= 1;
      end else if (busy && !scan_strobe) begin
        cmd_points <= {d3_buf, d12_buf, code_buf};
        scan_strobe <= 1;
        if (ptr + step >= N) begin
          ptr <= N - 1;
          busy <= 0;
        end else begin
          ptr <= ptr + step;
        end
      end
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the command front end
`timescale 1ns/1ps
`include "cnt_params.svh"
module tb;
  logic clk = 0, nrst = 0, start = 0, one = 0, count_pulse = 0;
  logic psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] one_word = 32'h0, pwdata = 32'h0, r;
  wire logic scan_strobe, busy, outputs_enable, counting, irq, pready, pslverr;
  wire logic [31:0] cmd_points, return_points, prdata;
  int n_fail = 0, checks_done = 0;
  `define CHK(nm, x, y) begin checks_done++; if ((y) !== (x)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", nm, x, y); end end
  always #4 clk = ~clk;
  host_seq host (.clk(clk), .nrst(nrst), .start(start), .one(one), .one_word(one_word),
    .scan_strobe(scan_strobe), .cmd_points(cmd_points), .busy(busy));
  cnt_cmd_front DUT (.clk(clk), .nrst(nrst), .scan_strobe(scan_strobe),
    .cmd_points(cmd_points), .count_pulse(count_pulse), .return_points(return_points),
    .outputs_enable(outputs_enable), .counting(counting), .irq(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait on pready; a hang ends the run as a mismatch
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    i = 0;
    do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin n_fail++; tally_and_finish(); end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // let an edge pass so a following call never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic send(input logic [31:0] w);
    one <= 1;
    one_word <= w;
    @(posedge clk);
    one <= 0;
    repeat (2) @(posedge clk);
  endtask
  // ********************
  // test sequence
  // ********************
  initial begin
    int i;
    repeat (5) @(posedge clk);
    `CHK("ret", 32'h0, return_points)
    `CHK("oe", 1'b0, outputs_enable)
    nrst <= 1;
    @(posedge clk);
    apb(0, `OFS_CTRL, 0);
    `CHK("ctrl", 32'h1, r)
    apb(1, `OFS_IRQ_EN, 32'h7);
    count_pulse <= 1;
    send(32'h21);
    send(`CMD_DISCRETE);
    count_pulse <= 0;
    `CHK("err", 16'h17E2, return_points[15:0])
    `CHK("oe", 1'b0, outputs_enable)
    apb(0, `OFS_ACCUM, 0);
    `CHK("acc", 32'h0, r)
    `CHK("irq", 1'b1, irq)
    apb(1, `OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    $display("test powerup done");
    start <= 1;
    @(posedge clk);
    start <= 0;
    @(posedge clk);
    for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge clk);
    if (i == 50) begin n_fail++; tally_and_finish(); end
    repeat (3) @(posedge clk);
    `CHK("oe", 1'b1, outputs_enable)
    `CHK("cnt", 1'b1, counting)
    `CHK("st", 8'h05, return_points[7:0])
    count_pulse <= 1;
    repeat (5) @(posedge clk);
    count_pulse <= 0;
    apb(0, `OFS_ACCUM, 0);
    `CHK("acc", 32'h5, r)
    apb(0, `OFS_IRQ_STAT, 0);
    `CHK("ist", 32'h6, r)
    apb(0, `OFS_LAST_CMD, 0);
    `CHK("last", 32'h0, r)
    `CHK("irq", 1'b1, irq)
    $display("test download done");
    apb(0, 8'h40, 0);
    `CHK("slverr", 1'b1, e)
    `CHK("rd", 32'h0, r)
    apb(1, `OFS_CTRL, 32'h0);
    send(`CMD_RESET);
    `CHK("oe", 1'b1, outputs_enable)
    apb(1, `OFS_CTRL, 32'h1);
    send(`CMD_RESET);
    `CHK("oe", 1'b0, outputs_enable)
    `CHK("cnt", 1'b0, counting)
    `CHK("st", 8'h02, return_points[7:0])
    $display("test reset done");
    tally_and_finish();
  end
endmodule

//--- verilog/cnt_cmd_front.sv
// command front end of the pulse counter module with apb status and interrupts
`timescale 1ns/1ps
`include "cnt_params.svh"
module cnt_cmd_front
  import cnt_pkg::*;
#(
  parameter int ACC_W = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scan_strobe,
  input wire logic [31:0] cmd_points,
  input wire logic count_pulse,
  output logic [31:0] return_points,
  output logic outputs_enable,
  output logic counting,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // helpers
  // ****************************************
  // a code that may run in the current power-up state
  function automatic logic cmd_allowed(input logic [7:0] code, input logic pwr);
    cmd_allowed = !pwr || code == `CMD_RESET || code == `CMD_CLR_PWR;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = a == `OFS_STATUS || a == `OFS_ACCUM || a == `OFS_CTRL ||
                 a == `OFS_IRQ_STAT || a == `OFS_IRQ_EN || a == `OFS_IRQ_CLR ||
                 a == `OFS_LAST_CMD;
  endfunction

  state_s state_reg;
  state_s state_next;

  logic [7:0] code;
  logic new_cmd;
  logic [`IRQ_W-1:0] ev;
  logic [7:0] status_byte;
  logic apb_done;

  assign code = cmd_points[7:0];
  assign new_cmd = scan_strobe && state_reg.accept &&
                   (!state_reg.prev_valid || cmd_points != state_reg.prev_cmd);
  assign apb_done = psel && penable && state_reg.pready;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    ev = '0;
    status_byte = '0;
    // counting only once enabled; pulses ignored before
    if (state_reg.cnt_en && count_pulse) begin
      state_next.accum = state_reg.accum + 24'h000001;
    end
    if (new_cmd) begin
      state_next.prev_valid = 1'b1;
      state_next.prev_cmd = cmd_points;
      state_next.last_cmd = cmd_points;
      if (!cmd_allowed(code, state_reg.pwr_up)) begin
        // refused: mode untouched, error shown on next scan
        state_next.err_pend = 1'b1;
        state_next.err_code = `ERR_PWR_UP;
        ev[`IRQ_ERR] = 1'b1;
      end else if (code == `CMD_RESET) begin
        // back to the power-up defaults
        state_next.pwr_up = 1'b1;
        state_next.cnt_en = 1'b0;
        state_next.out_en = 1'b0;
        state_next.accum = '0;
      end else if (code == `CMD_CLR_PWR) begin
        if (state_reg.pwr_up) begin
          ev[`IRQ_PWR_CLR] = 1'b1;
        end
        state_next.pwr_up = 1'b0;
      end else if (code == `CMD_DISCRETE) begin
        state_next.cnt_en = 1'b1;
        state_next.out_en = 1'b1;
        ev[`IRQ_ENABLED] = 1'b1;
      end
    end
    // return window refreshed each scan; error held for one scan only
    status_byte[`ST_CNT_BIT] = state_next.cnt_en;
    status_byte[`ST_PWR_BIT] = state_next.pwr_up;
    status_byte[`ST_OUT_BIT] = state_next.out_en;
    if (scan_strobe) begin
      if (state_reg.err_pend) begin
        status_byte[7:5] = `ERR_FLAG;
        state_next.ret = {16'h0000, state_reg.err_code, status_byte};
        state_next.err_pend = new_cmd && !cmd_allowed(code, state_reg.pwr_up);
      end else begin
        state_next.ret = {state_next.accum, status_byte};
      end
    end
    // apb slave: one wait cycle, then the access completes
    state_next.pready = psel && penable && !state_reg.pready;
    state_next.pslverr = psel && penable && !state_reg.pready && !addr_known(paddr);
    if (psel && penable && !state_reg.pready && !pwrite) begin
      unique case (paddr)
        `OFS_STATUS: state_next.prdata = {24'h000000, status_byte};
        `OFS_ACCUM: state_next.prdata = {8'h00, state_reg.accum};
        `OFS_CTRL: state_next.prdata = {31'h00000000, state_reg.accept};
        `OFS_IRQ_STAT: state_next.prdata = {29'h00000000, state_reg.irq_stat};
        `OFS_IRQ_EN: state_next.prdata = {29'h00000000, state_reg.irq_en};
        `OFS_LAST_CMD: state_next.prdata = state_reg.last_cmd;
        default: state_next.prdata = 32'h00000000;
      endcase
    end
    // sticky status: a new event wins over a clear in the same cycle
    state_next.irq_stat = state_reg.irq_stat;
    if (apb_done && pwrite) begin
      unique case (paddr)
        `OFS_CTRL: state_next.accept = pwdata[0];
        `OFS_IRQ_EN: state_next.irq_en = pwdata[`IRQ_W-1:0];
        `OFS_IRQ_CLR: state_next.irq_stat = state_reg.irq_stat & ~pwdata[`IRQ_W-1:0];
        default: state_next.accept = state_reg.accept;
      endcase
    end
    state_next.irq_stat = state_next.irq_stat | ev;
    state_next.irq = |(state_next.irq_stat & state_next.irq_en);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.pwr_up <= 1'b1;
      state_reg.accept <= `CTRL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign return_points = state_reg.ret;
  assign outputs_enable = state_reg.out_en;
  assign counting = state_reg.cnt_en;
  assign irq = state_reg.irq;
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;

  // ****************************************
  // checks
  // ****************************************
  a_pwr_refuse: assert property (@(posedge clk) disable iff (!nrst)
    new_cmd && state_reg.pwr_up && code != `CMD_RESET && code != `CMD_CLR_PWR
    |=> state_reg.pwr_up && $stable(state_reg.cnt_en) && $stable(state_reg.out_en))
    else $error("command run while power-up bit set");

  a_count_hold: assert property (@(posedge clk) disable iff (!nrst)
    !counting |=> state_reg.accum == $past(state_reg.accum))
    else $error("count moved while counting disabled");

  a_pwr_disabled: assert property (@(posedge clk) disable iff (!nrst)
    state_reg.pwr_up |-> !outputs_enable && !counting)
    else $error("enabled during power-up state");

  a_zero_enable: assert property (@(posedge clk) disable iff (!nrst)
    new_cmd && !state_reg.pwr_up && code == `CMD_DISCRETE |=> outputs_enable && counting)
    else $error("zero code did not enable");

  a_err_return: assert property (@(posedge clk) disable iff (!nrst)
    scan_strobe && state_reg.err_pend
    |=> return_points[15:8] == `ERR_PWR_UP && return_points[7:5] == `ERR_FLAG)
    else $error("error code 23 not returned");

  a_err_once: assert property (@(posedge clk) disable iff (!nrst)
    scan_strobe && !state_reg.err_pend |=> return_points[7:5] != `ERR_FLAG)
    else $error("error shown without a failed command");

  a_apb_answer: assert property (@(posedge clk) disable iff (!nrst)
    psel && penable && !pready |=> pready)
    else $error("apb access not answered in one cycle");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    $rose(state_reg.irq_stat[`IRQ_ERR]) && state_reg.irq_en[`IRQ_ERR] |-> irq)
    else $error("enabled event gave no interrupt");
endmodule

//--- verilog/cnt_params.svh
// constants of the counter module command front end
// Summary of operation
// - power-up set: only reset and clear-power-up accepted
// - after power-up outputs and counting stay disabled
// - command code zero enables outputs and counter
// - commands and returns use 32 point windows
// - erroneous command ignored, error returned next scan
// - refused power-up command returns error 23
`ifndef CNT_PARAMS_SVH
`define CNT_PARAMS_SVH
// command codes
`define CMD_DISCRETE 8'h00
`define CMD_RESET 8'h01
`define CMD_CLR_PWR 8'h06
// error codes and status byte layout
`define ERR_PWR_UP 8'h17
`define ERR_FLAG 3'h7
`define ST_CNT_BIT 0
`define ST_PWR_BIT 1
`define ST_OUT_BIT 2
// point windows
`define POINTS 32
// apb byte offsets
`define OFS_STATUS 8'h00
`define OFS_ACCUM 8'h04
`define OFS_CTRL 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_IRQ_CLR 8'h14
`define OFS_LAST_CMD 8'h18
// interrupt bits
`define IRQ_ERR 0
`define IRQ_ENABLED 1
`define IRQ_PWR_CLR 2
`define IRQ_W 3
`define CTRL_RST 1'h1
`endif

//--- verilog/cnt_pkg.sv
// types shared by the counter module command front end
package cnt_pkg;
  typedef struct packed {
    logic pwr_up;
    logic cnt_en;
    logic out_en;
    logic [23:0] accum;
    logic prev_valid;
    logic [31:0] prev_cmd;
    logic [31:0] last_cmd;
    logic [31:0] ret;
    logic err_pend;
    logic [7:0] err_code;
    logic accept;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;
endpackage
